//--- core/pin_cfg_pkg.sv
// Constants, encodings and lookup tables for the configuration pin loader
package pin_cfg_pkg;

  // ----------------------------------------------------------------
  // Pin classes and settings
  // ----------------------------------------------------------------
  localparam logic [1:0] CLS_LOW   = 2'h0;
  localparam logic [1:0] CLS_OPEN  = 2'h1;
  localparam logic [1:0] CLS_HIGH  = 2'h2;
  localparam logic [1:0] CLS_RES   = 2'h3;
  localparam int         NUM_CLASS = 4;
  localparam int         NUM_STRAP = 3;
  localparam int         NUM_RES   = 31;
  localparam int         CLS_W     = 2;
  localparam int         RES_W     = 5;
  localparam int         SEL_W     = 6;
  localparam logic [4:0] RES_TOP   = 5'h1e;
  localparam logic [5:0] SEL_RES0  = 6'h03;

  // ----------------------------------------------------------------
  // Pin roles and host index map
  // ----------------------------------------------------------------
  localparam int         PIN_ADDR   = 0;
  localparam int         PIN_LEVEL  = 1;
  localparam int         NUM_PINS   = 4;
  localparam int         NUM_MON    = 4;
  localparam int         IDX_W      = 4;
  localparam int         DATA_W     = 16;
  localparam logic [3:0] IDX_ADDR   = 4'h4;
  localparam logic [3:0] IDX_CEIL   = 4'h5;
  localparam logic [3:0] IDX_LIM0   = 4'h6;
  localparam logic [6:0] ADDR_BASE  = 7'h20;  // Arbitrary base bus address

  // ----------------------------------------------------------------
  // Output levels in millivolts
  // ----------------------------------------------------------------
  localparam int MV_W     = 13;
  localparam int CEIL_W   = 14;
  localparam int CEIL_DIV = 10;
  localparam logic [12:0] STRAP_MV [NUM_STRAP] = '{13'd1200, 13'd1500, 13'd3300};
  localparam logic [12:0] RES_MV [NUM_RES] = '{
    13'd600,  13'd700,  13'd750,  13'd800,  13'd900,  13'd1000, 13'd1100, 13'd1200,
    13'd1250, 13'd1300, 13'd1400, 13'd1500, 13'd1600, 13'd1700, 13'd1800, 13'd1900,
    13'd2000, 13'd2100, 13'd2200, 13'd2300, 13'd2400, 13'd2500, 13'd2600, 13'd2700,
    13'd2800, 13'd2900, 13'd3000, 13'd3100, 13'd3200, 13'd3300, 13'd5000};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int CHECK_TIME_US = 5000;
  localparam int CHECK_CYCLES  = CHECK_TIME_US * CLK_MHZ;
  localparam int CNT_W         = 24;

  typedef enum logic [1:0] {
    ST_CHECK,
    ST_SAMPLE,
    ST_READY
  } load_state_e;

  function automatic logic [12:0] level_mv(input logic [5:0] sel);
    if (sel < SEL_RES0) begin
      level_mv = STRAP_MV[sel[1:0]];
    end else begin
      level_mv = RES_MV[5'(sel - SEL_RES0)];
    end
  endfunction : level_mv

endpackage : pin_cfg_pkg

//--- core/pin_sense_if.sv
// Carrier between the pin sampler and the pin class decoder
`timescale 1ns/1ps
interface pin_sense_if #(
  parameter int N = pin_cfg_pkg::NUM_PINS
);
  logic [N-1:0][pin_cfg_pkg::CLS_W-1:0] cls;
  logic [N-1:0][pin_cfg_pkg::RES_W-1:0] res;
  logic [N-1:0][pin_cfg_pkg::SEL_W-1:0] sel;

  modport src (output cls, output res, input  sel);
  modport dec (input  cls, input  res, output sel);
endinterface : pin_sense_if

//--- core/pin_class_decoder.sv
// Maps each sensed pin class and resistor code onto a setting index
`timescale 1ns/1ps
module pin_class_decoder #(
  parameter int N = pin_cfg_pkg::NUM_PINS
) (
  pin_sense_if.dec sense     // Sensed pins in, settings out
);

  for (genvar p = 0; p < N; p++) begin : g_pin
    always_comb begin
      if (sense.cls[p] != pin_cfg_pkg::CLS_RES) begin
        // Low, open or high pick one of three settings
        sense.sel[p] = {4'h0, sense.cls[p]};
      end else if (sense.res[p] > pin_cfg_pkg::RES_TOP) begin
        sense.sel[p] = pin_cfg_pkg::SEL_RES0 + {1'b0, pin_cfg_pkg::RES_TOP};
      end else begin
        sense.sel[p] = pin_cfg_pkg::SEL_RES0 + {1'b0, sense.res[p]};
      end
    end
  end

endmodule : pin_class_decoder

//--- core/pin_cfg_loader.sv
// Power-up configuration pin loader with host overwrite and monitor alerts
`timescale 1ns/1ps
module pin_cfg_loader #(
  parameter int N            = pin_cfg_pkg::NUM_PINS,
  parameter int CHECK_CYCLES = pin_cfg_pkg::CHECK_CYCLES
) (
  input  wire logic                                   clk_i,          // 25 MHz clock
  input  wire logic                                   rst_i,          // Async power-on reset
  input  wire logic [N-1:0][pin_cfg_pkg::CLS_W-1:0]   pin_class_i,    // Sensed pin class
  input  wire logic [N-1:0][pin_cfg_pkg::RES_W-1:0]   pin_res_i,      // Sensed resistor code
  input  wire logic                                   enable_i,       // Enable pin
  input  wire logic                                   restore_i,      // Restore command pulse
  input  wire logic                                   cmd_valid_i,    // Host request valid
  input  wire logic                                   cmd_write_i,    // Host request is write
  input  wire logic [pin_cfg_pkg::IDX_W-1:0]          cmd_idx_i,      // Host parameter index
  input  wire logic [pin_cfg_pkg::DATA_W-1:0]         cmd_wdata_i,    // Host write data
  input  wire logic [pin_cfg_pkg::NUM_MON-1:0][pin_cfg_pkg::DATA_W-1:0] mon_i, // Monitored
  output logic                                        cmd_ready_o,    // Host request taken
  output logic                                        rsp_valid_o,    // Read data valid
  output logic [pin_cfg_pkg::DATA_W-1:0]              rsp_rdata_o,    // Read data
  output logic [N-1:0][pin_cfg_pkg::SEL_W-1:0]        setting_o,      // Working settings
  output logic [6:0]                                  address_select_pin_o, // Bus address
  output logic [pin_cfg_pkg::MV_W-1:0]                level_mv_o,     // Output level, mV
  output logic [pin_cfg_pkg::CEIL_W-1:0]              output_ceiling_limit_o, // Ceiling, mV
  output logic                                        enable_o,       // Gated enable
  output logic                                        busy_o,         // Checks in progress
  output logic                                        alert_o         // Monitor alert
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int SENSE_W = pin_cfg_pkg::CLS_W + pin_cfg_pkg::RES_W;

  typedef struct packed {
    logic [N-1:0][SENSE_W-1:0]                              sync1;
    logic [N-1:0][SENSE_W-1:0]                              sync2;
    logic [1:0]                                             en_sync;
    pin_cfg_pkg::load_state_e                               st;
    logic [pin_cfg_pkg::CNT_W-1:0]                          cnt;
    logic [N-1:0][pin_cfg_pkg::SEL_W-1:0]                   set;
    logic [6:0]                                             addr;
    logic [pin_cfg_pkg::CEIL_W-1:0]                         ceil;
    logic [pin_cfg_pkg::MV_W-1:0]                           level;
    logic [pin_cfg_pkg::NUM_MON-1:0][pin_cfg_pkg::DATA_W-1:0] lim;
    logic                                                   alert;
    logic                                                   en;
    logic                                                   rsp_valid;
    logic [pin_cfg_pkg::DATA_W-1:0]                         rsp_data;
  } loader_s;

  loader_s r_r;
  loader_s r_nxt;

  pin_sense_if #(.N(N)) sense ();

  pin_class_decoder #(.N(N)) u_dec (
    .sense (sense.dec)
  );

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  for (genvar p = 0; p < N; p++) begin : g_sense
    assign sense.cls[p] = r_r.sync2[p][SENSE_W-1:pin_cfg_pkg::RES_W];
    assign sense.res[p] = r_r.sync2[p][pin_cfg_pkg::RES_W-1:0];
  end

  logic [pin_cfg_pkg::MV_W-1:0]      pin_mv;
  logic [6:0]                        pin_addr;
  logic [pin_cfg_pkg::CEIL_W-1:0]    pin_ceil;

  assign pin_mv   = pin_cfg_pkg::level_mv(sense.sel[pin_cfg_pkg::PIN_LEVEL]);
  assign pin_addr = pin_cfg_pkg::ADDR_BASE
                    + {1'b0, sense.sel[pin_cfg_pkg::PIN_ADDR]};
  // Ceiling is the sensed level plus a tenth, rounded down
  assign pin_ceil = {1'b0, pin_mv}
                    + {1'b0, pin_mv / pin_cfg_pkg::MV_W'(pin_cfg_pkg::CEIL_DIV)};

  // ----------------------------------------------------------------
  // Host request decode
  // ----------------------------------------------------------------
  logic                              taken;
  logic                              wr_taken;
  logic                              rd_taken;
  logic                              idx_is_pin;
  logic                              idx_is_lim;
  logic [pin_cfg_pkg::IDX_W-1:0]     lim_idx;

  assign cmd_ready_o = (r_r.st == pin_cfg_pkg::ST_READY);
  assign taken       = cmd_valid_i && cmd_ready_o;
  // Restore wins over a request in the same cycle
  assign wr_taken    = taken && cmd_write_i && !restore_i;
  assign rd_taken    = taken && !cmd_write_i && !restore_i;
  assign lim_idx     = cmd_idx_i - pin_cfg_pkg::IDX_LIM0;
  assign idx_is_pin  = (cmd_idx_i < pin_cfg_pkg::IDX_W'(N));
  assign idx_is_lim  = (cmd_idx_i >= pin_cfg_pkg::IDX_LIM0)
                       && (lim_idx < pin_cfg_pkg::IDX_W'(pin_cfg_pkg::NUM_MON));

  // ----------------------------------------------------------------
  // Monitor limits and level lookup
  // ----------------------------------------------------------------
  // Settings past the table top read as the top level
  localparam logic [pin_cfg_pkg::SEL_W-1:0] SEL_TOP =
    pin_cfg_pkg::SEL_RES0 + {1'b0, pin_cfg_pkg::RES_TOP};

  logic [pin_cfg_pkg::NUM_MON-1:0]   over;
  logic [pin_cfg_pkg::SEL_W-1:0]     level_sel;

  // Alert is a plain level, gone once all values drop back
  for (genvar m = 0; m < pin_cfg_pkg::NUM_MON; m++) begin : g_mon
    assign over[m] = (mon_i[m] > r_r.lim[m]);
  end

  assign level_sel = (r_r.set[pin_cfg_pkg::PIN_LEVEL] > SEL_TOP) ? SEL_TOP
                     : r_r.set[pin_cfg_pkg::PIN_LEVEL];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    for (int p = 0; p < N; p++) begin
      r_nxt.sync1[p] = {pin_class_i[p], pin_res_i[p]};
    end
    r_nxt.sync2 = r_r.sync1;
    r_nxt.en_sync = {r_r.en_sync[0], enable_i};
    r_nxt.rsp_valid = 1'b0;

    case (r_r.st)
      pin_cfg_pkg::ST_CHECK: begin
        if (r_r.cnt >= pin_cfg_pkg::CNT_W'(CHECK_CYCLES - 1)) begin
          r_nxt.cnt = '0;
          r_nxt.st = pin_cfg_pkg::ST_SAMPLE;
        end else begin
          r_nxt.cnt = r_r.cnt + 1'b1;
        end
      end
      pin_cfg_pkg::ST_SAMPLE: begin
        // Only place where pin values are taken
        r_nxt.set = sense.sel;
        r_nxt.addr = pin_addr;
        r_nxt.ceil = pin_ceil;
        r_nxt.st = pin_cfg_pkg::ST_READY;
      end
      pin_cfg_pkg::ST_READY: begin
        if (restore_i) begin
          r_nxt.st = pin_cfg_pkg::ST_CHECK;
          r_nxt.cnt = '0;
        end else if (wr_taken) begin
          if (idx_is_pin) begin
            // Address pin setting is pin-only
            if (cmd_idx_i != pin_cfg_pkg::IDX_W'(pin_cfg_pkg::PIN_ADDR)) begin
              r_nxt.set[cmd_idx_i] = cmd_wdata_i[pin_cfg_pkg::SEL_W-1:0];
            end
          end else if (idx_is_lim) begin
            r_nxt.lim[lim_idx[1:0]] = cmd_wdata_i;
          end
        end else if (rd_taken) begin
          r_nxt.rsp_valid = 1'b1;
          r_nxt.rsp_data = '0;
          if (idx_is_pin) begin
            r_nxt.rsp_data = {10'h000, r_r.set[cmd_idx_i]};
          end else if (cmd_idx_i == pin_cfg_pkg::IDX_ADDR) begin
            r_nxt.rsp_data = {9'h000, r_r.addr};
          end else if (cmd_idx_i == pin_cfg_pkg::IDX_CEIL) begin
            r_nxt.rsp_data = {2'h0, r_r.ceil};
          end else if (idx_is_lim) begin
            r_nxt.rsp_data = r_r.lim[lim_idx[1:0]];
          end
        end
      end
      default: begin
        r_nxt.st = pin_cfg_pkg::ST_CHECK;
        r_nxt.cnt = '0;
      end
    endcase

    // Working output level follows the level pin setting
    r_nxt.level = pin_cfg_pkg::level_mv(level_sel);
    // Enable is ignored while checks run
    r_nxt.en = r_r.en_sync[1] && (r_r.st == pin_cfg_pkg::ST_READY);
    r_nxt.alert = |over;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_r     <= '0;
      r_r.st  <= pin_cfg_pkg::ST_CHECK;
      r_r.lim <= '1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid_o            = r_r.rsp_valid;
  assign rsp_rdata_o            = r_r.rsp_data;
  assign setting_o              = r_r.set;
  assign address_select_pin_o   = r_r.addr;
  assign level_mv_o             = r_r.level;
  assign output_ceiling_limit_o = r_r.ceil;
  assign enable_o               = r_r.en;
  assign busy_o                 = (r_r.st != pin_cfg_pkg::ST_READY);
  assign alert_o                = r_r.alert;

endmodule : pin_cfg_loader

//--- verification/strap_board.sv
// Board strap model driving every configuration pin alike
`timescale 1ns/1ps
module strap_board #(
  parameter int N = 4
) (
  input  wire logic [1:0]        cls_i,        // Connection class
  input  wire logic [4:0]        code_i,       // Resistor code
  output logic      [N-1:0][1:0] pin_class_o,  // Sensed class
  output logic      [N-1:0][4:0] pin_res_o     // Sensed code
);
  always_comb begin
    for (int p = 0; p < N; p++) begin
      pin_class_o[p] = cls_i;
      pin_res_o[p]   = (cls_i == 2'h3) ? code_i : ~code_i;
    end
  end
endmodule : strap_board

//--- verification/pin_cfg_assertions.sv
// Port checker for the configuration pin loader
`timescale 1ns/1ps
module pin_cfg_assertions #(
  parameter int N            = 4,
  parameter int CHECK_CYCLES = 16
) (
  input wire logic        clk_i,                   // Clock
  input wire logic        rst_i,                   // Reset
  input wire logic        restore_i,               // Restore
  input wire logic        cmd_valid_i,             // Request
  input wire logic        cmd_write_i,             // Write
  input wire logic        cmd_ready_o,             // Taken
  input wire logic        rsp_valid_o,             // Read valid
  input wire logic [6:0]  address_select_pin_o,    // Address
  input wire logic [12:0] level_mv_o,              // Level
  input wire logic [13:0] output_ceiling_limit_o,  // Ceiling
  input wire logic        enable_o,                // Enable
  input wire logic        busy_o,                  // Busy
  input wire logic        alert_o                  // Alert
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int unsigned busy_len;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) busy_len <= 0;
    else busy_len <= busy_o ? busy_len + 1 : 0;
  end
  read_rsp_a: assert property (cmd_valid_i && !cmd_write_i && cmd_ready_o && !restore_i
    |=> rsp_valid_o) else $error("read not answered");
  no_rsp_a: assert property (!(cmd_valid_i && !cmd_write_i && cmd_ready_o) |=> !rsp_valid_o)
    else $error("spurious read answer");
  busy_refuse_a: assert property (busy_o |-> !cmd_ready_o) else $error("ready while busy");
  enable_gate_a: assert property (busy_o |=> !enable_o) else $error("enable while busy");
  restore_start_a: assert property (restore_i && cmd_ready_o |=> busy_o)
    else $error("restore ignored");
  check_len_a: assert property ($fell(busy_o) |-> busy_len == CHECK_CYCLES + 1)
    else $error("check span wrong");
  reset_check_a: assert property ($fell(rst_i) |-> busy_o [*8]) else $error("check cut short");
  addr_hold_a: assert property (!busy_o ##1 !busy_o |-> $stable(address_select_pin_o))
    else $error("address changed");
  ceil_hold_a: assert property (!busy_o ##1 !busy_o |-> $stable(output_ceiling_limit_o))
    else $error("ceiling changed");
  ceil_calc_a: assert property ($fell(busy_o) |=>
    output_ceiling_limit_o == 14'(level_mv_o) + 14'(level_mv_o / 13'd10))
    else $error("ceiling not level plus tenth");
  read_c: cover property (rsp_valid_o);
  restore_c: cover property (restore_i && cmd_ready_o);
  alert_c: cover property ($rose(alert_o));
endmodule : pin_cfg_assertions

bind pin_cfg_loader pin_cfg_assertions #(.N(N), .CHECK_CYCLES(CHECK_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .restore_i(restore_i), .cmd_valid_i(cmd_valid_i),
  .cmd_write_i(cmd_write_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
  .address_select_pin_o(address_select_pin_o), .level_mv_o(level_mv_o),
  .output_ceiling_limit_o(output_ceiling_limit_o), .enable_o(enable_o),
  .busy_o(busy_o), .alert_o(alert_o));

//--- verification/tb_top.sv
// Testbench for the configuration pin loader
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [1:0] c; logic [4:0] r; logic [5:0] s; logic [12:0] mv;} row_s;
  row_s rows [6] = '{'{2'h0, 5'h00, 6'h00, 13'd1200}, '{2'h1, 5'h00, 6'h01, 13'd1500},
    '{2'h2, 5'h00, 6'h02, 13'd3300}, '{2'h3, 5'h00, 6'h03, 13'd600},
    '{2'h3, 5'h1e, 6'h21, 13'd5000}, '{2'h3, 5'h1f, 6'h21, 13'd5000}};
  logic             clk_i = 1'b0, rst_i = 1'b1, enable_i = 1'b0, restore_i = 1'b0;
  logic             cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
  logic [1:0]       cls = 2'h0;
  logic [4:0]       code = 5'h00;
  logic [3:0]       cmd_idx_i = 4'h0;
  logic [15:0]      cmd_wdata_i = 16'h0000, q;
  logic [3:0][15:0] mon_i = '0;
  logic [3:0][1:0]  pin_class;
  logic [3:0][4:0]  pin_res;
  logic [3:0][5:0]  setting_o;
  logic             cmd_ready_o, rsp_valid_o, enable_o, busy_o, alert_o;
  logic [15:0]      rsp_rdata_o;
  logic [6:0]       addr_o;
  logic [12:0]      level_o;
  logic [13:0]      ceil_o;
  int               n_errors = 0, n_compared = 0;

  always #20 clk_i = ~clk_i;
  strap_board #(.N(4)) u_strap_board (.cls_i(cls), .code_i(code),
    .pin_class_o(pin_class), .pin_res_o(pin_res));
  pin_cfg_loader #(.N(4), .CHECK_CYCLES(16)) u_pin_cfg_loader (.clk_i(clk_i), .rst_i(rst_i),
    .pin_class_i(pin_class), .pin_res_i(pin_res), .enable_i(enable_i), .restore_i(restore_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_idx_i(cmd_idx_i),
    .cmd_wdata_i(cmd_wdata_i), .mon_i(mon_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .setting_o(setting_o),
    .address_select_pin_o(addr_o), .level_mv_o(level_o), .output_ceiling_limit_o(ceil_o),
    .enable_o(enable_o), .busy_o(busy_o), .alert_o(alert_o));

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic wait_idle();
    for (int i = 0; i < 60 && busy_o !== 1'b0; i++) @(negedge clk_i);
    @(negedge clk_i);
  endtask : wait_idle

  task automatic restore();
    @(negedge clk_i) restore_i = 1'b1;
    @(negedge clk_i) restore_i = 1'b0;
    wait_idle();
  endtask : restore

  task automatic host(input logic w, input logic [3:0] i, input logic [15:0] d);
    @(negedge clk_i);
    {cmd_valid_i, cmd_write_i, cmd_idx_i, cmd_wdata_i} = {1'b1, w, i, d};
    for (int k = 0; k < 60 && cmd_ready_o !== 1'b1; k++) @(negedge clk_i);
    @(negedge clk_i) cmd_valid_i = 1'b0;
    q = rsp_rdata_o;
    if (!w) chk("rsp_valid", 16'(rsp_valid_o), 16'h1);
  endtask : host

  initial begin
    #100000 n_errors++;
    wrap_up();
  end

  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    chk("busy", 16'(busy_o), 16'h1);
    wait_idle();
    foreach (rows[k]) begin
      {cls, code} = {rows[k].c, rows[k].r};
      restore();
      chk("setting", 16'(setting_o[1]), 16'(rows[k].s));
      chk("addr", 16'(addr_o), 16'(pin_cfg_pkg::ADDR_BASE + 7'(rows[k].s)));
      chk("level", 16'(level_o), 16'(rows[k].mv));
      chk("ceil", 16'(ceil_o), 16'(rows[k].mv + rows[k].mv / 13'd10));
    end
    host(1'b1, 4'h1, 16'h000a);
    @(negedge clk_i);
    chk("level", 16'(level_o), 16'd1200);
    chk("ceil", 16'(ceil_o), 16'd5500);
    host(1'b0, 4'h1, 16'h0000);
    chk("rd_set", q, 16'h000a);
    host(1'b1, 4'h1, 16'h003f);
    repeat (2) @(negedge clk_i);
    chk("level_top", 16'(level_o), 16'd5000);
    host(1'b1, 4'h1, 16'h000a);
    host(1'b1, 4'h4, 16'h0003);
    host(1'b0, 4'h4, 16'h0000);
    chk("rd_addr", q, 16'h0041);
    host(1'b0, 4'h5, 16'h0000);
    chk("rd_ceil", q, 16'd5500);
    host(1'b0, 4'hf, 16'h0000);
    chk("rd_none", q, 16'h0000);
    host(1'b1, 4'h0, 16'h0001);
    host(1'b0, 4'h0, 16'h0000);
    chk("rd_pin0", q, 16'h0021);
    host(1'b1, 4'h6, 16'd100);
    host(1'b0, 4'h6, 16'h0000);
    chk("rd_lim", q, 16'd100);
    mon_i[0] = 16'd100;
    repeat (3) @(negedge clk_i);
    chk("alert", 16'(alert_o), 16'h0);
    mon_i[0] = 16'd101;
    repeat (2) @(negedge clk_i);
    chk("alert", 16'(alert_o), 16'h1);
    {cls, enable_i} = {2'h0, 1'b1};
    repeat (5) @(negedge clk_i);
    chk("hold", 16'(setting_o[1]), 16'h000a);
    chk("enable", 16'(enable_o), 16'h1);
    @(negedge clk_i) restore_i = 1'b1;
    @(negedge clk_i) restore_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("enable", 16'(enable_o), 16'h0);
    chk("ready", 16'(cmd_ready_o), 16'h0);
    wait_idle();
    chk("resample", 16'(setting_o[1]), 16'h0000);
    rst_i = 1'b1;
    @(negedge clk_i) rst_i = 1'b0;
    chk("busy", 16'(busy_o), 16'h1);
    wait_idle();
    chk("busy", 16'(busy_o), 16'h0);
    wrap_up();
  end
endmodule : tb_top
